// ==== dv/sacp_link_chk.sv ====
// Checker on the three link wires between host and device
`timescale 1ns/10ps
`default_nettype none
module sacp_link_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link wires
  input wire logic convert_start_n,
  input wire logic shift_clk,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic data_line
);
  logic       sclk_q, cs_q, rise, fall, ev;
  logic [4:0] n_q, n_d;
  // Edges found by sampling the raw wires, two cycles ahead of the device's synchronisers
  assign rise = shift_clk & ~sclk_q;
  assign fall = ~convert_start_n & cs_q;
  assign ev   = rise | fall;
  // Rising clock edges since the last start, saturating
  always_comb begin
    n_d = n_q;
    if (fall) begin
      n_d = 5'h00;
    end else if (rise && n_q != 5'h1f) begin
      n_d = n_q + 5'h01;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b1;
      cs_q   <= 1'b1;
      n_q    <= 5'h00;
    end else begin
      sclk_q <= shift_clk;
      cs_q   <= convert_start_n;
      n_q    <= n_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_fall; fall; endsequence
  sequence s_drive; data_oe && !data_o; endsequence
  property p_oe; s_fall |-> ##[1:4] s_drive; endproperty
  a_oe: assert property (p_oe) else $error("output not driven low");
  property p_lead;
    data_oe && n_q >= 5'h02 && n_q <= 5'h03 |-> !data_line;
  endproperty
  a_lead: assert property (p_lead) else $error("lead bit not zero");
  property p_upd;
    data_oe && $past(data_oe) && $changed(data_o)
      |-> $past(ev) || $past(ev, 2) || $past(ev, 3);
  endproperty
  a_upd: assert property (p_upd) else $error("output moved off edge");
  property p_acq; fall && n_q >= 5'h0e |-> n_q >= 5'h11; endproperty
  a_acq: assert property (p_acq) else $error("acquisition short");
  property p_rel;
    $rose(convert_start_n) && n_q >= 5'h0e |-> n_q <= 5'h0f;
  endproperty
  a_rel: assert property (p_rel) else $error("start released late");
  property p_pd; $rose(convert_start_n) && n_q != 5'h00 |-> n_q >= 5'h03;
  endproperty
  a_pd: assert property (p_pd) else $error("start released early");
  property p_clk; s_fall |-> ##[1:40] rise; endproperty
  a_clk: assert property (p_clk) else $error("no clock after start");
  property p_max; rise && !convert_start_n |-> n_q <= 5'h10; endproperty
  a_max: assert property (p_max) else $error("frame too long");
endmodule : sacp_link_chk
`default_nettype wire

// ==== dv/test_serial_adc_conversion_port.sv ====
// Bench: host and device joined over the link, results checked
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_serial_adc_conversion_port;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        run = 1'b0;
  logic        power_down = 1'b0;
  logic        res_ready = 1'b0;
  logic [11:0] sample_in = 12'h000;
  logic        acquiring, busy, result_ok, res_valid;
  logic [1:0]  power_mode;
  logic [11:0] res_data;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cnt, k;
  logic [11:0] smp [4] = '{12'h000, 12'hfff, 12'h800, 12'h5a3};
  logic [11:0] expv [4] = '{12'h000, 12'hfff, 12'h800, 12'h5a3};
  sacp_link_if u_link ();
  sacp_device u_sacp_device (.clock(clock), .sys_rst(sys_rst),
    .link(u_link.device), .sample_in(sample_in), .acquiring(acquiring),
    .busy(busy), .power_mode(power_mode), .result_ok(result_ok));
  // Short power-up wait keeps the run brief
  sacp_host #(.PWRUP_CYCLES(100)) u_sacp_host (.clock(clock),
    .sys_rst(sys_rst), .link(u_link.host), .run(run),
    .power_down(power_down), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));
  sacp_link_chk u_sacp_link_chk (.clock(clock), .sys_rst(sys_rst),
    .convert_start_n(u_link.convert_start_n),
    .shift_clk(u_link.shift_clk), .data_o(u_link.data_o),
    .data_oe(u_link.data_oe), .data_line(u_link.data_line));
  always #10 clock = ~clock;
  task finish_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Inputs move 1 ns after the edge
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task wait_res(input int lim);
    k = 0;
    while (res_valid !== 1'b1 && k < lim) begin
      step(1);
      k++;
    end
    if (res_valid !== 1'b1) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_res
  // Pops everything that arrives; each word must match the sample
  task drain(input logic [11:0] e);
    cnt = 0;
    res_ready = 1'b1;
    repeat (300) begin
      step(1);
      if (res_valid === 1'b1) begin
        cnt++;
        `CHK(res_data, e)
      end
    end
    res_ready = 1'b0;
  endtask : drain
  initial begin
    step(3);
    `CHK(u_link.data_oe, 1'b0)
    `CHK(acquiring, 1'b1)
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      sample_in = smp[i];
      run = 1'b1;
      wait_res(400);
      run = 1'b0;
      drain(expv[i]);
      `CHK(acquiring, 1'b1)
    end
    // Full buffer must stall the link, not drop words
    sample_in = 12'h3c5;
    run = 1'b1;
    step(1600);
    run = 1'b0;
    drain(12'h3c5);
    `CHK(cnt >= sacp_pkg::FIFO_DEPTH, 1'b1)
    power_down = 1'b1;
    run = 1'b1;
    k = 0;
    while (power_mode !== sacp_pkg::SACP_PWR_FULL && k < 3000) begin
      step(1);
      k++;
    end
    `CHK(power_mode, sacp_pkg::SACP_PWR_FULL)
    power_down = 1'b0;
    sample_in = 12'h0a5;
    wait_res(3000);
    run = 1'b0;
    drain(12'h0a5);
    `CHK(power_mode, sacp_pkg::SACP_PWR_ON)
    run = 1'b1;
    step(30);
    sys_rst = 1'b1;
    step(3);
    `CHK(u_link.data_oe, 1'b0)
    finish_test();
  end
endmodule : test_serial_adc_conversion_port
`default_nettype wire

// ==== verilog/sacp_device.sv ====
// Converter end: conversion control, power modes and serial output
// Function
// R1 - Falling start edge samples, begins conversion
// R2 - Host holds start high to arm
// R3 - Output bit updates on rising clock edge
// R4 - Host clock paces conversion and shifting
// R5 - Conversion lasts sixteen clock cycles
// R6 - Acquisition from 14th edge until next start
// R7 - Idle device stays in acquisition
// R8 - Host allows three acquisition cycles
// R9 - Partial power-down exit needs 16 cycles
// R10 - Full power-down exit needs 2 ms
// R11 - Frame is three zeros then 12 bits
// R12 - MSB appears on 4th rising edge
// R13 - Host raises start between edges 14 and 16
// R14 - Early start release enters power-down modes
// R15 - Output floats until start falls, then low; after a full frame ending with start high it stays driven low
`timescale 1ns/10ps
`default_nettype none
module sacp_device (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // Link
  sacp_link_if.device          link,
  // Analog stand-in: value to convert, sampled at start
  input  wire logic [11:0]     sample_in,
  // Status
  output logic                 acquiring,
  output logic                 busy,
  output logic [1:0]           power_mode,
  output logic                 result_ok
);
  localparam logic [4:0] E_MSB  = 5'(sacp_pkg::MSB_EDGE);
  localparam logic [4:0] E_LZ   = 5'(sacp_pkg::LEAD_ZEROS);
  localparam logic [4:0] E_ACQ  = 5'(sacp_pkg::ACQ_EDGE);
  localparam logic [4:0] E_END  = 5'(sacp_pkg::FRAME_EDGES);
  localparam logic [4:0] E_PD   = 5'(sacp_pkg::PD_LO_EDGE);
  localparam logic [4:0] E_RCV  = 5'(sacp_pkg::partial_restart_cycles);

  // Two-flop synchronisers on the pins
  logic [1:0] cs_sync_q, ck_sync_q;
  logic       cs_prev_q, ck_prev_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cs_sync_q <= 2'h3;
      ck_sync_q <= 2'h0;
      cs_prev_q <= 1'b1;
      ck_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], link.convert_start_n};
      ck_sync_q <= {ck_sync_q[0], link.shift_clk};
      cs_prev_q <= cs_sync_q[1];
      ck_prev_q <= ck_sync_q[1];
    end
  end

  logic cs_fall, cs_rise, ck_rise, ck_fall;
  assign cs_fall = cs_prev_q && !cs_sync_q[1];
  assign cs_rise = !cs_prev_q && cs_sync_q[1];
  assign ck_rise = !ck_prev_q && ck_sync_q[1];
  assign ck_fall = ck_prev_q && !ck_sync_q[1];

  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_TAIL} sacp_dev_st_t;

  sacp_dev_st_t    st_q, st_d;
  logic [4:0]      edge_q, edge_d;
  logic [11:0]     hold_q, hold_d;
  logic [15:0]     sh_q, sh_d;
  logic            do_q, do_d, oe_q, oe_d;
  logic [1:0]      pwr_q, pwr_d;
  logic [4:0]      wake_q, wake_d;
  logic            ok_q, ok_d;
  logic            pd_hit;

  // Conversion sequencer, paced only by host clock edges
  always_comb begin
    st_d   = st_q;
    edge_d = edge_q;
    hold_d = hold_q;
    sh_d   = sh_q;
    do_d   = do_q;
    oe_d   = oe_q;
    pwr_d  = pwr_q;
    wake_d = wake_q;
    ok_d   = ok_q;
    pd_hit = 1'b0;
    unique case (st_q)
      ST_ACQ, ST_TAIL: begin
        // R15 output high impedance when the tail ends, on clock or start rise
        if (st_q == ST_TAIL && (ck_rise || cs_rise)) begin
          oe_d = 1'b0;
          st_d = ST_ACQ;
        end
        // R1 sample on start fall
        if (cs_fall) begin
          st_d   = ST_CONV;
          edge_d = sacp_pkg::EDGE_CNT_RST;
          hold_d = sample_in;
          // R11 three zeros then data
          sh_d   = {3'h0, sample_in, 1'b0};
          // R15 drive low at start
          do_d   = 1'b0;
          oe_d   = 1'b1;
        end
      end
      ST_CONV: begin
        // R4 host clock paces the conversion
        if (ck_rise) begin
          edge_d = 5'(edge_q + 5'h01);
          // R3 R12 shift on rising edge, MSB at edge four
          if (5'(edge_q + 5'h01) >= E_MSB - E_LZ) begin
            do_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end
          // R9 count wake edges after power-down
          if (wake_q != 5'h00) begin
            wake_d = 5'(wake_q - 5'h01);
          end
        end
        // R14 early release enters power-down
        if (cs_rise && edge_q >= E_PD && edge_q < E_ACQ) begin
          pd_hit = 1'b1;
          pwr_d  = (pwr_q == 2'(sacp_pkg::SACP_PWR_ON)) ?
                   2'(sacp_pkg::SACP_PWR_PARTIAL) :
                   2'(sacp_pkg::SACP_PWR_FULL);
          st_d   = ST_ACQ;
          oe_d   = 1'b0;
          ok_d   = 1'b0;
        end else if (ck_fall && edge_q == E_END) begin
          // R5 frame complete after sixteen cycles
          st_d = cs_sync_q[1] ? ST_ACQ : ST_TAIL;
          ok_d = (wake_q == 5'h00) &&
                 (pwr_q == 2'(sacp_pkg::SACP_PWR_ON));
          // R13 start still low keeps line driven into tail
          if (!cs_sync_q[1]) begin
            oe_d = 1'b1;
          end
        end
        // R9 R10 full-length frame wakes device
        if (!pd_hit && pwr_q != 2'(sacp_pkg::SACP_PWR_ON) &&
            cs_rise && edge_q >= E_ACQ) begin
          pwr_d  = 2'(sacp_pkg::SACP_PWR_ON);
          wake_d = E_RCV;
        end
      end
      default: st_d = ST_ACQ;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= ST_ACQ;
      edge_q <= sacp_pkg::EDGE_CNT_RST;
      hold_q <= 12'h000;
      sh_q   <= 16'h0000;
      do_q   <= 1'b0;
      oe_q   <= 1'b0;
      pwr_q  <= 2'(sacp_pkg::SACP_PWR_ON);
      wake_q <= 5'h00;
      ok_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      edge_q <= edge_d;
      hold_q <= hold_d;
      sh_q   <= sh_d;
      do_q   <= do_d;
      oe_q   <= oe_d;
      pwr_q  <= pwr_d;
      wake_q <= wake_d;
      ok_q   <= ok_d;
    end
  end

  // R6 R7 acquisition from edge fourteen and when idle
  logic acq_d;
  always_comb begin
    acq_d = (st_d != ST_CONV) || (edge_d >= E_ACQ);
  end

  logic acq_q, busy_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      acq_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      acq_q  <= acq_d;
      busy_q <= (st_d == ST_CONV);
    end
  end

  assign link.data_o  = do_q;
  assign link.data_oe = oe_q;
  assign acquiring    = acq_q;
  assign busy         = busy_q;
  assign power_mode   = pwr_q;
  assign result_ok    = ok_q;
endmodule : sacp_device
`default_nettype wire

// ==== verilog/sacp_fifo.sv ====
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sacp_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Pointer and count bookkeeping
  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
endmodule : sacp_fifo
`default_nettype wire

// ==== verilog/sacp_host.sv ====
// Host end: makes the link clock, frames conversions, buffers results
`timescale 1ns/10ps
`default_nettype none
module sacp_host #(
  parameter int unsigned PWRUP_CYCLES = sacp_pkg::PWRUP_CYCLES
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // Link
  sacp_link_if.host            link,
  // User control
  input  wire logic            run,
  input  wire logic            power_down,
  // Result stream
  output logic                 res_valid,
  input  wire logic            res_ready,
  output logic [11:0]          res_data
);
  localparam logic [4:0]  E_ACQ  = 5'(sacp_pkg::ACQ_EDGE);
  localparam logic [4:0]  E_END  = 5'(sacp_pkg::FRAME_EDGES);
  localparam logic [4:0]  E_PD   = 5'(sacp_pkg::PD_LO_EDGE + 1);
  localparam logic [4:0]  E_GAP  = 5'(sacp_pkg::ACQ_CYCLES);
  localparam logic [4:0]  E_MSB  = 5'(sacp_pkg::MSB_EDGE);
  localparam logic [4:0]  E_LAST = 5'(E_ACQ + E_GAP);
  localparam logic [23:0] PWR_N  = 24'(PWRUP_CYCLES);
  localparam logic [3:0]  HALF   = 4'(sacp_pkg::SCLK_HALF);

  typedef enum logic [1:0] {H_IDLE, H_FRAME, H_PWAIT} sacp_host_st_t;

  // Data line comes from the far end: two flops before use
  logic [1:0] din_sync_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      din_sync_q <= 2'h3;
    end else begin
      din_sync_q <= {din_sync_q[0], link.data_line};
    end
  end

  sacp_host_st_t st_q, st_d;
  logic [3:0]    div_q, div_d;
  logic [4:0]    rc_q, rc_d;
  logic          cs_q, cs_d, sclk_q, sclk_d;
  logic          pdf_q, pdf_d;   // Frame is a power-down frame
  logic [1:0]    lvl_q, lvl_d;   // Power-down depth set so far
  logic          wake_q, wake_d; // Next full frame only wakes
  logic          keep_q, keep_d; // Result of this frame is kept
  logic [23:0]   pw_q, pw_d;
  logic [11:0]   sh_q, sh_d;
  logic          rv_q, rv_d;
  logic [11:0]   rd_q, rd_d;
  logic          tick, push, out_take;
  logic          f_ready, f_valid;
  logic [11:0]   f_data;

  // Framing, divider and readout; the link clock stands outside frames
  always_comb begin
    st_d     = st_q;
    rc_d     = rc_q;
    cs_d     = cs_q;
    sclk_d   = sclk_q;
    pdf_d    = pdf_q;
    lvl_d    = lvl_q;
    wake_d   = wake_q;
    keep_d   = keep_q;
    pw_d     = pw_q;
    sh_d     = sh_q;
    push     = 1'b0;
    tick     = (div_q == HALF - 4'h1);
    div_d    = tick ? 4'h0 : 4'(div_q + 4'h1);
    out_take = !rv_q || res_ready;
    rv_d     = out_take ? f_valid : rv_q;
    rd_d     = (out_take && f_valid) ? f_data : rd_q;
    unique case (st_q)
      H_IDLE: begin
        // R2 start held high arms the device
        if (tick && run && f_ready &&
            !(power_down && lvl_q == 2'h2)) begin
          st_d   = H_FRAME;
          cs_d   = 1'b0;
          rc_d   = 5'h00;
          pdf_d  = power_down;
          keep_d = !power_down && !wake_q;
        end
      end
      H_FRAME: begin
        if (tick) begin
          // R4 host clock paces conversion
          sclk_d = !sclk_q;
          if (!sclk_q) begin
            rc_d = 5'(rc_q + 5'h01);
            // Bit of the previous rise is read at this one
            if (rc_d > E_MSB && rc_d <= E_END) begin
              sh_d = {sh_q[10:0], din_sync_q[1]};
            end
          end else if (pdf_q) begin
            // R14 early release powers down
            if (rc_q == E_PD) begin
              cs_d   = 1'b1;
              st_d   = H_IDLE;
              lvl_d  = (lvl_q == 2'h0) ? 2'h1 : 2'h2;
              wake_d = 1'b1;
            end
          end else begin
            // R13 release after fourteenth rise
            if (rc_q == E_ACQ) begin
              cs_d = 1'b1;
            end
            // R5 sixteen cycles complete word
            if (rc_q == E_END && keep_q) begin
              push = 1'b1;
            end
            // R8 three acquisition cycles kept
            if (rc_q == E_LAST) begin
              // R9 wake frame covers restart
              wake_d = 1'b0;
              lvl_d  = 2'h0;
              st_d   = (wake_q && lvl_q == 2'h2) ? H_PWAIT : H_IDLE;
              pw_d   = PWR_N;
            end
          end
        end
      end
      H_PWAIT: begin
        // R10 power-up wait after full
        if (pw_q == 24'h000000) begin
          st_d = H_IDLE;
        end else begin
          pw_d = 24'(pw_q - 24'h000001);
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= H_IDLE;
      div_q  <= 4'h0;
      rc_q   <= 5'h00;
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
      pdf_q  <= 1'b0;
      lvl_q  <= 2'h0;
      wake_q <= 1'b0;
      keep_q <= 1'b0;
      pw_q   <= 24'h000000;
      sh_q   <= 12'h000;
      rv_q   <= 1'b0;
      rd_q   <= 12'h000;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      rc_q   <= rc_d;
      cs_q   <= cs_d;
      sclk_q <= sclk_d;
      pdf_q  <= pdf_d;
      lvl_q  <= lvl_d;
      wake_q <= wake_d;
      keep_q <= keep_d;
      pw_q   <= pw_d;
      sh_q   <= sh_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
    end
  end

  // Results wait here; a frame starts only with room for its word
  sacp_fifo #(
    .WIDTH (sacp_pkg::DATA_W),
    .DEPTH (sacp_pkg::FIFO_DEPTH)
  ) u_sacp_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (sh_q),
    .out_valid (f_valid),
    .out_ready (out_take),
    .out_data  (f_data)
  );

  assign link.convert_start_n = cs_q;
  assign link.shift_clk       = sclk_q;
  assign res_valid            = rv_q;
  assign res_data             = rd_q;
endmodule : sacp_host
`default_nettype wire

// ==== verilog/sacp_link_if.sv ====
// Three-wire link between host master and converter port
`timescale 1ns/10ps
`default_nettype none
interface sacp_link_if;
  logic convert_start_n;
  logic shift_clk;
  logic data_o;
  logic data_oe;
  // Resolved line level seen by the host; floats high when undriven
  logic data_line;
  assign data_line = data_oe ? data_o : 1'b1;
  modport device (input convert_start_n, input shift_clk,
                  output data_o, output data_oe);
  modport host (output convert_start_n, output shift_clk,
                input data_line);
endinterface : sacp_link_if
`default_nettype wire

// ==== verilog/sacp_pkg.sv ====
// Shared constants for the serial converter port, both ends
package sacp_pkg;
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned LEAD_ZEROS    = 3;
  localparam int unsigned FRAME_EDGES   = 16;
  localparam int unsigned ACQ_EDGE      = 14;
  localparam int unsigned MSB_EDGE      = 4;
  localparam int unsigned PD_LO_EDGE    = 3;
  localparam int unsigned ACQ_CYCLES    = 3;
  localparam int unsigned partial_restart_cycles = 16;
  // Full power-up wait, time and derived system clock count
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned PWRUP_US      = 2000;
  localparam int unsigned PWRUP_CYCLES  = PWRUP_US * (CLK_HZ / 1_000_000);
  // Host divider: half period of the link clock in system cycles
  // Four cycles: the device answers three cycles after a rise and the
  // host's own two-flop sampler must still see that bit before the next
  localparam int unsigned SCLK_HALF     = 4;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam logic [4:0]  EDGE_CNT_RST  = 5'h00;
  typedef enum logic [1:0] {
    SACP_PWR_ON, SACP_PWR_PARTIAL, SACP_PWR_FULL
  } sacp_pwr_t;
endpackage : sacp_pkg
